// [rtl/dscp_top.sv]
// Purpose: Serial command port: 24-bit frames, commit strobe, read-back, chain mode.
// Assumes: Serial clock and strobe are far slower than the system clock.
// Notes:   Serial pins and fault status pass two flip-flops before any logic reads them; rst_n is used directly.
//
// Notes on behaviour
// [R01] 24-bit frame, MSB first on rising edges.
// [R02] Bits 23:16 address, bits 15:0 data.
// [R03] Host shifts exactly 24 bits before strobe.
// [R04] Shift regardless of strobe; commit at rise.
// [R05] Shift register clears at reset.
// [R06] Decode the nine command address bytes.
// [R07] Read command uses data bits 5:0 only.
// [R08] Read selector picks one of six registers.
// [R09] Host sends a following frame for read-back.
// [R10] Read-back MSB first on falling edges.
// [R11] Wrong clock count corrupts registers and read-back.
// [R12] Chain mode passes shifted bits to output.
// [R13] Chain of N needs N times 24 clocks.
// [R14] Chain write one frame, read two; joint commit.
// [R15] Second read frame may carry another command.
// [R16] Gated clock burst holds exact count, then strobe.
// [R17] Read commit loads selected value for next frame.
module dscp_top
  import dscp_pkg::*;
(
  // System
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Serial pins
  input  wire logic          serial_clock_pin,
  input  wire logic          serial_input_line,
  input  wire logic          commit_strobe_pin,
  output logic               serial_output_line,
  // Converter core
  input  wire logic [15:0]   fault_status_in,
  output dscp_regs_type      regs_r,
  output logic               watchdog_restart_r
);

  // ****************************************
  // Pin synchronisers and edge detection
  // ****************************************
  logic [SYNC_DEPTH-1:0] sclk_sync_r;
  logic [SYNC_DEPTH-1:0] sdi_sync_r;
  logic [SYNC_DEPTH-1:0] strobe_sync_r;
  logic [15:0]           status_meta_r;
  logic [15:0]           status_r;
  logic                  sclk_prev_r;
  logic                  strobe_prev_r;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  commit;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_sync_r   <= '0;
      sdi_sync_r    <= '0;
      strobe_sync_r <= '0;
      status_meta_r <= REG_RESET;
      status_r      <= REG_RESET;
      sclk_prev_r   <= 1'b0;
      strobe_prev_r <= 1'b0;
    end else begin
      sclk_sync_r   <= {sclk_sync_r[0], serial_clock_pin};
      sdi_sync_r    <= {sdi_sync_r[0], serial_input_line};
      strobe_sync_r <= {strobe_sync_r[0], commit_strobe_pin};
      status_meta_r <= fault_status_in;
      status_r      <= status_meta_r;
      sclk_prev_r   <= sclk_sync_r[1];
      strobe_prev_r <= strobe_sync_r[1];
    end
  end

  assign sclk_rise = sclk_sync_r[1] & ~sclk_prev_r;
  assign sclk_fall = ~sclk_sync_r[1] & sclk_prev_r;
  assign commit    = strobe_sync_r[1] & ~strobe_prev_r; // [R04]

  // ****************************************
  // Frame fields and command decode
  // ****************************************
  logic [FRAME_BITS-1:0] shift_r;
  logic [7:0]            cmd;
  logic [15:0]           word;
  logic                  soft_reset;
  logic                  chain_mode_enable;
  logic [15:0]           read_value;

  assign cmd               = shift_r[ADDR_MSB:ADDR_LSB]; // [R02]
  assign word              = shift_r[DATA_BITS-1:0]; // [R02]
  assign soft_reset        = commit && cmd == CMD_RESET && word[RESET_BIT_POS];
  assign chain_mode_enable = regs_r.output_control[CHAIN_BIT_POS];

  always_comb begin
    read_value = REG_RESET;
    unique case (word[1:0]) // [R07] [R08]
      SEL_STATUS:  read_value = status_r;
      SEL_DATA:    read_value = regs_r.converter_data;
      SEL_CONTROL: read_value = regs_r.output_control;
      default: begin
        if (word[5:0] == SEL_CONFIG) begin
          read_value = regs_r.configuration;
        end else if (word[5:0] == SEL_GAIN) begin
          read_value = regs_r.gain_calibration;
        end else if (word[5:0] == SEL_ZERO) begin
          read_value = regs_r.zero_calibration;
        end
      end
    endcase
  end

  // ****************************************
  // Shift register
  // ****************************************
  // A read commit or a soft reset has priority over a shift edge in the same cycle; other commits do not.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= SHIFT_RESET; // [R05]
    end else if (soft_reset) begin
      shift_r <= SHIFT_RESET; // [R05]
    end else if (commit && cmd == CMD_READ) begin
      shift_r <= {8'h00, read_value}; // [R17]
    end else if (sclk_rise) begin
      shift_r <= {shift_r[FRAME_BITS-2:0], sdi_sync_r[1]}; // [R01]
    end
  end

  // Holds the bit that left the top of the frame, so the first fall shows the old MSB.
  logic shift_out_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_out_r <= 1'b0;
    end else if (soft_reset || (commit && cmd == CMD_READ)) begin
      shift_out_r <= 1'b0;
    end else if (sclk_rise) begin
      shift_out_r <= shift_r[ADDR_MSB]; // [R10] [R12]
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regs_r <= '0;
    end else if (soft_reset) begin
      regs_r <= '0;
    end else if (commit) begin
      unique case (cmd) // [R06] [R14]
        CMD_DATA:    regs_r.converter_data <= word;
        CMD_CONTROL: begin
          regs_r.output_control <= word;
          if (word[RANGE_MSB:0] != regs_r.output_control[RANGE_MSB:0]) begin
            regs_r.converter_data <= REG_RESET;
          end
        end
        CMD_CONFIG:  regs_r.configuration    <= word;
        CMD_GAIN:    regs_r.gain_calibration <= word;
        CMD_ZERO:    regs_r.zero_calibration <= word;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_restart_r <= 1'b0;
    end else begin
      watchdog_restart_r <= commit && cmd == CMD_WDOG; // [R06]
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  logic read_active_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      read_active_r <= 1'b0;
    end else if (commit) begin
      read_active_r <= cmd == CMD_READ && !soft_reset; // [R17]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serial_output_line <= 1'b0;
    end else if (commit) begin
      serial_output_line <= 1'b0;
    end else if (sclk_fall) begin
      serial_output_line <= (read_active_r | chain_mode_enable) & shift_out_r; // [R10] [R12]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_shift_capture: assert property (sclk_rise && !commit |=>
      shift_r == {$past(shift_r[FRAME_BITS-2:0]), $past(sdi_sync_r[1])}) // [R01]
    else $error("Shift register did not capture the input bit.");
  a_data_write: assert property (commit && cmd == CMD_DATA |=>
      regs_r.converter_data == $past(word)) // [R02]
    else $error("Converter data not written from the frame.");
  a_ctrl_write: assert property (commit && cmd == CMD_CONTROL |=>
      regs_r.output_control == $past(word) ##[1:40] $stable(regs_r.output_control)) // [R06]
    else $error("Control register not written.");
  a_nop_hold: assert property (commit && cmd == CMD_NOP |=> $stable(regs_r)) // [R04]
    else $error("No-operation changed a register.");
  a_soft_clear: assert property (soft_reset |=> shift_r == SHIFT_RESET && regs_r == '0) // [R05]
    else $error("Soft reset did not clear state.");
  a_read_load: assert property (commit && cmd == CMD_READ |=>
      shift_r[15:0] == $past(read_value) && read_active_r) // [R17]
    else $error("Read value not loaded for output.");
  a_read_select: assert property (commit && cmd == CMD_READ && word[1:0] == SEL_CONTROL |=>
      shift_r[15:0] == $past(regs_r.output_control)) // [R08]
    else $error("Read selector picked the wrong register.");
  a_out_msb: assert property (sclk_fall && !commit && (read_active_r || chain_mode_enable)
      |=> serial_output_line == $past(shift_out_r)) // [R10]
    else $error("Output bit is not the shift register MSB.");
  a_out_quiet: assert property (sclk_fall && !commit && !read_active_r && !chain_mode_enable
      |=> !serial_output_line) // [R12]
    else $error("Output driven outside read or chain mode.");
  a_wdog_pulse: assert property (commit && cmd == CMD_WDOG |=>
      watchdog_restart_r ##1 !watchdog_restart_r) // [R06]
    else $error("Watchdog restart not a single pulse.");

  c_read_frame:  cover property (commit && cmd == CMD_NOP && read_active_r);
  c_chain_out:   cover property (chain_mode_enable && sclk_fall && shift_r[ADDR_MSB]);
  c_data_write:  cover property (commit && cmd == CMD_DATA);
  c_range_clear: cover property (commit && cmd == CMD_CONTROL && word[RANGE_MSB:0] != 3'h0);

endmodule

// [rtl/dscp_pkg.sv]
// Purpose: Shared constants and types for the serial command port.
// Assumes: One system clock; the serial pins are asynchronous to it.
// Notes:   Frame layout, command bytes, read selectors and control fields.
package dscp_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 24;
  localparam int ADDR_MSB   = 23;
  localparam int ADDR_LSB   = 16;
  localparam int DATA_BITS  = 16;
  localparam int SYNC_DEPTH = 2;
  localparam logic [23:0] SHIFT_RESET = 24'h000000;

  // ****************************************
  // Command address bytes
  // ****************************************
  localparam logic [7:0] CMD_NOP     = 8'h00;
  localparam logic [7:0] CMD_DATA    = 8'h01;
  localparam logic [7:0] CMD_READ    = 8'h02;
  localparam logic [7:0] CMD_CONTROL = 8'h55;
  localparam logic [7:0] CMD_RESET   = 8'h56;
  localparam logic [7:0] CMD_CONFIG  = 8'h57;
  localparam logic [7:0] CMD_GAIN    = 8'h58;
  localparam logic [7:0] CMD_ZERO    = 8'h59;
  localparam logic [7:0] CMD_WDOG    = 8'h95;

  // ****************************************
  // Read selectors and register fields
  // ****************************************
  localparam logic [1:0] SEL_STATUS  = 2'h0;
  localparam logic [1:0] SEL_DATA    = 2'h1;
  localparam logic [1:0] SEL_CONTROL = 2'h2;
  localparam logic [5:0] SEL_CONFIG  = 6'h0b;
  localparam logic [5:0] SEL_GAIN    = 6'h13;
  localparam logic [5:0] SEL_ZERO    = 6'h17;
  localparam int RESET_BIT_POS = 0;
  localparam int CHAIN_BIT_POS = 3;
  localparam int RANGE_MSB     = 2;
  localparam logic [15:0] REG_RESET = 16'h0000;

  typedef struct packed {
    logic [15:0] converter_data;
    logic [15:0] output_control;
    logic [15:0] configuration;
    logic [15:0] gain_calibration;
    logic [15:0] zero_calibration;
  } dscp_regs_type;

endpackage

// [verif/dscp_host_model.sv]
// Purpose: Host model that shifts 24-bit frames into the command port.
// Assumes: Bench clock of 5 ns; serial clock period of 80 ns.
// Notes:   Read-back bits are gathered just before each rising serial edge after the first, and once more before the strobe.
module dscp_host_model (
  // System
  input  wire logic clock,
  // Serial pins
  output logic      ser_clk,
  output logic      ser_in,
  output logic      strobe,
  input  wire logic ser_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    ser_clk = 1'b0;
    ser_in  = 1'b0;
    strobe  = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Shifts exactly 24 bits in one burst, then raises the strobe.
  task automatic frame(input logic [23:0] f, output logic [23:0] rd);
    for (int i = 23; i >= 0; i--) begin
      ser_in = f[i];
      pause(8);
      if (i != 23) rd = {rd[22:0], ser_out};
      ser_clk = 1'b1;
      pause(8);
      ser_clk = 1'b0;
    end
    pause(8);
    rd      = {rd[22:0], ser_out};
    ser_in  = ~ser_in;
    strobe  = 1'b1;
    pause(8);
    strobe  = 1'b0;
    pause(8);
  endtask
endmodule

// [verif/dscp_top_tb.sv]
// Purpose: Self-checking bench for the serial command port.
// Assumes: Host model drives the serial clock, input and strobe pins; the port drives the output line.
// Notes:   Each scenario is a task that judges its own results.
module dscp_top_tb
  import dscp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clock;
  logic          rst_n;
  logic          ser_clk;
  logic          ser_in;
  logic          strobe;
  logic          ser_out;
  logic [15:0]   status;
  dscp_regs_type regs;
  logic          wdog;
  logic [23:0]   rd;
  int            n_fail = 0;
  int            check_count = 0;
  int            wd_seen = 0;

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  dscp_top dscp_top_i (.clock(clock), .rst_n(rst_n), .serial_clock_pin(ser_clk),
    .serial_input_line(ser_in), .commit_strobe_pin(strobe), .serial_output_line(ser_out),
    .fault_status_in(status), .regs_r(regs), .watchdog_restart_r(wdog));
  dscp_host_model dscp_host_model_i (.clock(clock), .ser_clk(ser_clk), .ser_in(ser_in),
    .strobe(strobe), .ser_out(ser_out));

  always @(negedge clock) if (wdog === 1'b1) wd_seen++;

  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_write_read;
    logic [7:0]  c [5] = '{CMD_CONTROL, CMD_DATA, CMD_CONFIG, CMD_GAIN, CMD_ZERO};
    logic [15:0] v [5] = '{16'h1235, 16'ha5c3, 16'h002a, 16'h8001, 16'h7ffe};
    logic [5:0]  s [5] = '{6'h3e, 6'h3d, SEL_CONFIG, SEL_GAIN, SEL_ZERO};
    for (int i = 0; i < 5; i++) dscp_host_model_i.frame({c[i], v[i]}, rd);
    check(regs, {v[1], v[0], v[2], v[3], v[4]});
    for (int i = 0; i < 5; i++) begin
      dscp_host_model_i.frame({CMD_READ, 10'h3ff, s[i]}, rd);
      dscp_host_model_i.frame({CMD_NOP, 16'h0000}, rd);
      check({56'h0, rd}, {64'h0, v[i]});
    end
    dscp_host_model_i.frame({CMD_READ, 10'h155, 6'h3c}, rd);
    dscp_host_model_i.frame({CMD_NOP, 16'h0000}, rd);
    check({56'h0, rd}, {64'h0, status});
  endtask

  task automatic t_misc;
    int            w0;
    dscp_regs_type keep;
    w0   = wd_seen;
    keep = regs;
    dscp_host_model_i.frame({CMD_WDOG, 16'h0000}, rd);
    check(80'(wd_seen - w0), 80'h1);
    dscp_host_model_i.frame({8'h33, 16'hffff}, rd);
    dscp_host_model_i.frame({CMD_NOP, 16'hffff}, rd);
    check(regs, keep);
  endtask

  task automatic t_chain;
    dscp_host_model_i.frame({CMD_CONTROL, 16'h123d}, rd);
    dscp_host_model_i.frame({CMD_NOP, 16'hbeef}, rd);
    dscp_host_model_i.frame({CMD_NOP, 16'h0000}, rd);
    check({56'h0, rd}, {56'h0, CMD_NOP, 16'hbeef});
    dscp_host_model_i.frame({CMD_READ, 10'h000, 6'h3d}, rd);
    dscp_host_model_i.frame({CMD_GAIN, 16'h4321}, rd);
    check({56'h0, rd}, {64'h0, 16'ha5c3});
    check({64'h0, regs.gain_calibration}, {64'h0, 16'h4321});
    dscp_host_model_i.frame({CMD_CONTROL, 16'h1235}, rd);
  endtask

  task automatic t_hard_reset;
    dscp_host_model_i.frame({CMD_DATA, 16'h3c5a}, rd);
    check({64'h0, regs.converter_data}, {64'h0, 16'h3c5a});
    rst_n = 1'b0;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    check(regs, 80'h0);
    check({78'h0, wdog, ser_out}, 80'h0);
  endtask

  task automatic t_soft_reset;
    dscp_host_model_i.frame({CMD_RESET, 16'h0001}, rd);
    check(regs, 80'h0);
    check({79'h0, ser_out}, 80'h0);
  endtask

  initial begin
    rst_n  = 1'b0;
    status = 16'h5a21;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    check(regs, 80'h0);
    check({78'h0, wdog, ser_out}, 80'h0);
    t_write_read;
    t_misc;
    t_chain;
    t_hard_reset;
    t_soft_reset;
    give_verdict;
  end
endmodule
